//--- rseq_consts.vh
/*
 constants for the rail enable sequencing logic: register offsets, reset values,
 field positions, pin-select codes and delay figures.
 assumes it is included by bare name from the design files.
*/
`ifndef RSEQ_CONSTS_VH
`define RSEQ_CONSTS_VH

// register offsets
`define RSEQ_ADDR_MASK_A        8'h10
`define RSEQ_ADDR_SEL_MASK_B    8'h11
`define RSEQ_ADDR_DELAYS        8'h12
`define RSEQ_ADDR_R5_MASK_A     8'h13

// reset values (one-time-programmable defaults)
`define RSEQ_RST_MASK_A         8'h00
`define RSEQ_RST_SEL_MASK_B     8'h80
`define RSEQ_RST_DELAYS         8'h00
`define RSEQ_RST_R5_MASK_A      8'h00

// field positions
`define RSEQ_SEL_MSB            4
`define RSEQ_SEL_LSB            2
`define RSEQ_MASKB_MSB          1
`define RSEQ_MASKB_LSB          0
`define RSEQ_MASKA_MSB          7
`define RSEQ_FALL_MSB           5
`define RSEQ_FALL_LSB           3
`define RSEQ_RISE_MSB           2
`define RSEQ_RISE_LSB           0

// pin-select codes
`define RSEQ_SEL_CONTROL_INPUT_1           3'h0
`define RSEQ_SEL_CONTROL_INPUT_2           3'h1
`define RSEQ_SEL_CONTROL_INPUT_5           3'h2
`define RSEQ_SEL_CONTROL_INPUT_4           3'h3
`define RSEQ_SEL_CONTROL_INPUT_3           3'h4
`define RSEQ_SEL_CONTROL_INPUT_4_ALT       3'h5
`define RSEQ_SEL_CONTROL_INPUT_6           3'h6
`define RSEQ_SEL_FORCE          3'h7

// delay figures in ms per code
`define RSEQ_DLY_C0             7'h00
`define RSEQ_DLY_C1             7'h02
`define RSEQ_DLY_C2             7'h04
`define RSEQ_DLY_C3             7'h08
`define RSEQ_DLY_C4             7'h10
`define RSEQ_DLY_C5             7'h18
`define RSEQ_DLY_C6             7'h20
`define RSEQ_DLY_C7             7'h40

// timing
`define RSEQ_CLK_NS             25
`define RSEQ_MS_NS              1000000
`define RSEQ_MS_CYCLES          16'd40000

// input counts
`define RSEQ_NUM_PG             10
`define RSEQ_NUM_SYNC           16

`endif

//--- rseq_edge_delay.v
/*
 programmable rising/falling edge delay for one enable signal.
 assumes req is already synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rseq_consts.vh"

module rseq_edge_delay #(
	parameter [15:0] MS_CYCLES = 16'd40000
) (
	input  wire       core_clk,
	input  wire       resetn,
	input  wire       req,
	input  wire [2:0] rise_code,
	input  wire [2:0] fall_code,
	output wire       en,
	output wire       pending
);

	reg  [15:0] div_q;
	reg  [6:0]  ms_q;
	reg         en_q;
	wire [6:0]  target;
	wire        tick;

	// code to delay in ms, shared by both edges
	function [6:0] delay_ms;
		input [2:0] code;
		begin
			case (code)
				3'h0: delay_ms = `RSEQ_DLY_C0;
				3'h1: delay_ms = `RSEQ_DLY_C1;
				3'h2: delay_ms = `RSEQ_DLY_C2;
				3'h3: delay_ms = `RSEQ_DLY_C3;
				3'h4: delay_ms = `RSEQ_DLY_C4;
				3'h5: delay_ms = `RSEQ_DLY_C5;
				3'h6: delay_ms = `RSEQ_DLY_C6;
				default: delay_ms = `RSEQ_DLY_C7;
			endcase
		end
	endfunction

	assign target  = req ? delay_ms(rise_code) : delay_ms(fall_code);
	assign pending = (req != en_q);
	assign tick    = (div_q == (MS_CYCLES - 16'd1));
	assign en      = en_q;

	// ms divider restarts with each pending edge, so the delay is exact
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= 16'h0000;
			ms_q  <= 7'h00;
			en_q  <= 1'b0;
		end else if (!pending) begin
			div_q <= 16'h0000;
			ms_q  <= 7'h00;
		end else if ((target == 7'h00) || (tick && ((ms_q + 7'h01) == target))) begin
			en_q  <= req; // nominal delay, inside the tolerance band
			div_q <= 16'h0000;
			ms_q  <= 7'h00;
		end else if (tick) begin
			div_q <= 16'h0000;
			ms_q  <= ms_q + 7'h01;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

endmodule // rseq_edge_delay
`default_nettype wire

//--- rseq_top.v
/*
 enable qualification for the target switching rail: input select, power-good
 masking, edge delays and the configuration registers behind them.
 assumes a simple synchronous register port from the serial interface logic,
 and control and power-good inputs that are asynchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rseq_consts.vh"

module rseq_top #(
	parameter [15:0] MS_CYCLES = `RSEQ_MS_CYCLES
) (
	input  wire       core_clk,
	input  wire       resetn,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr_en,
	input  wire       reg_rd_en,
	output reg  [7:0] reg_rdata,
	output reg        reg_rvalid,
	input  wire       control_input_1,
	input  wire       control_input_2,
	input  wire       control_input_3,
	input  wire       control_input_4,
	input  wire       control_input_5,
	input  wire       control_input_6,
	input  wire [9:0] power_good_flag,
	output wire       target_switching_rail_enable,
	output wire       enable_delay_pending,
	output wire       enable_request,
	output wire [7:0] rail5_mask_a_out
);

	// configuration registers
	reg  [7:0] rail4_power_good_mask_a_q;
	reg  [7:0] rail4_pin_select_and_mask_b_q;
	reg  [7:0] rail4_edge_delays_q;
	reg  [7:0] rail5_power_good_mask_a_q;

	// synchroniser chains and filtered values
	reg  [`RSEQ_NUM_SYNC-1:0] sync1_q;
	reg  [`RSEQ_NUM_SYNC-1:0] sync2_q;
	reg  [`RSEQ_NUM_SYNC-1:0] sync3_q;
	reg  [`RSEQ_NUM_SYNC-1:0] filt_q;
	wire [`RSEQ_NUM_SYNC-1:0] raw_in;

	wire [5:0] ctl_clean;
	wire [9:0] pg_clean;
	wire [9:0] pg_mask;
	wire [9:0] pg_ok;
	wire [2:0] rail4_enable_input_select;
	wire [2:0] rail4_turnoff_delay;
	wire [2:0] rail4_turnon_delay;
	wire       rail4_mask_combined_switch_b2;
	wire       rail4_mask_switch_b1;
	wire       rail4_mask_linear_a3;
	wire       ctl_selected;
	wire       all_good;
	reg        enable_req_q;

	// address decode shared by write and read paths
	function [1:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
				`RSEQ_ADDR_MASK_A:     reg_index = 2'h0;
				`RSEQ_ADDR_SEL_MASK_B: reg_index = 2'h1;
				`RSEQ_ADDR_DELAYS:     reg_index = 2'h2;
				default:               reg_index = 2'h3;
			endcase
		end
	endfunction

	function addr_hit;
		input [7:0] addr;
		begin
			addr_hit = (addr == `RSEQ_ADDR_MASK_A) || (addr == `RSEQ_ADDR_SEL_MASK_B) ||
				(addr == `RSEQ_ADDR_DELAYS) || (addr == `RSEQ_ADDR_R5_MASK_A);
		end
	endfunction

	// register writes; unmapped offsets are ignored
	// a read in the same cycle as a write returns the old value
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rail4_power_good_mask_a_q     <= `RSEQ_RST_MASK_A;
			rail4_pin_select_and_mask_b_q <= `RSEQ_RST_SEL_MASK_B;
			rail4_edge_delays_q           <= `RSEQ_RST_DELAYS;
			rail5_power_good_mask_a_q     <= `RSEQ_RST_R5_MASK_A;
		end else if (reg_wr_en && addr_hit(reg_addr)) begin
			case (reg_index(reg_addr))
				2'h0: rail4_power_good_mask_a_q <= reg_wdata;
				2'h1: rail4_pin_select_and_mask_b_q <= reg_wdata;
				2'h2: rail4_edge_delays_q <= reg_wdata;
				default: rail5_power_good_mask_a_q <= reg_wdata;
			endcase
		end
	end

	// register reads, one cycle latency; unmapped reads return zero
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd_en;
			if (reg_rd_en) begin
				if (!addr_hit(reg_addr)) begin
					reg_rdata <= 8'h00;
				end else begin
					case (reg_index(reg_addr))
						2'h0: reg_rdata <= rail4_power_good_mask_a_q;
						2'h1: reg_rdata <= rail4_pin_select_and_mask_b_q;
						2'h2: reg_rdata <= rail4_edge_delays_q;
						default: reg_rdata <= rail5_power_good_mask_a_q;
					endcase
				end
			end
		end
	end

	// field views
	assign rail4_enable_input_select     = rail4_pin_select_and_mask_b_q[`RSEQ_SEL_MSB:`RSEQ_SEL_LSB];
	assign rail4_mask_combined_switch_b2 = rail4_pin_select_and_mask_b_q[`RSEQ_MASKB_MSB];
	assign rail4_mask_switch_b1          = rail4_pin_select_and_mask_b_q[`RSEQ_MASKB_LSB];
	assign rail4_mask_linear_a3          = rail4_power_good_mask_a_q[`RSEQ_MASKA_MSB];
	assign rail4_turnoff_delay           = rail4_edge_delays_q[`RSEQ_FALL_MSB:`RSEQ_FALL_LSB];
	assign rail4_turnon_delay            = rail4_edge_delays_q[`RSEQ_RISE_MSB:`RSEQ_RISE_LSB];

	// asynchronous inputs: three flops, accept when stages two and three agree
	assign raw_in = {power_good_flag, control_input_6, control_input_5, control_input_4,
		control_input_3, control_input_2, control_input_1};

	// pins and power-good share one chain so both see the same latency
	genvar gi;
	generate
		for (gi = 0; gi < `RSEQ_NUM_SYNC; gi = gi + 1) begin : g_sync
			always @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					filt_q[gi]  <= 1'b0;
				end else begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi]) begin
						filt_q[gi] <= sync3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign ctl_clean = filt_q[5:0];
	assign pg_clean  = filt_q[`RSEQ_NUM_SYNC-1:6];

	// control input multiplexer
	function ctl_mux;
		input [2:0] sel;
		input [5:0] ctl;
		begin
			case (sel)
				`RSEQ_SEL_CONTROL_INPUT_1:     ctl_mux = ctl[0];
				`RSEQ_SEL_CONTROL_INPUT_2:     ctl_mux = ctl[1];
				`RSEQ_SEL_CONTROL_INPUT_5:     ctl_mux = ctl[4];
				`RSEQ_SEL_CONTROL_INPUT_4:     ctl_mux = ctl[3];
				`RSEQ_SEL_CONTROL_INPUT_3:     ctl_mux = ctl[2];
				`RSEQ_SEL_CONTROL_INPUT_4_ALT: ctl_mux = ctl[3];
				`RSEQ_SEL_CONTROL_INPUT_6:     ctl_mux = ctl[5];
				default:            ctl_mux = 1'b1;
			endcase
		end
	endfunction

	assign ctl_selected = ctl_mux(rail4_enable_input_select, ctl_clean);

	// power-good masking: a set mask bit removes that rail from the decision
	assign pg_mask = {rail4_mask_combined_switch_b2,
		rail4_mask_switch_b1,
		rail4_mask_linear_a3,
		rail4_power_good_mask_a_q[6:0]};
	assign pg_ok    = pg_clean | pg_mask;
	assign all_good = &pg_ok;

	// registered enable request feeds the edge delay
	// the register keeps mux and mask settling out of the delay counter
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			enable_req_q <= 1'b0;
		end else begin
			enable_req_q <= ctl_selected & all_good;
		end
	end

	rseq_edge_delay #(
		.MS_CYCLES (MS_CYCLES)
	) u_delay (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.req       (enable_req_q),
		.rise_code (rail4_turnon_delay),
		.fall_code (rail4_turnoff_delay),
		.en        (target_switching_rail_enable),
		.pending   (enable_delay_pending)
	);

	assign enable_request   = enable_req_q;
	assign rail5_mask_a_out = rail5_power_good_mask_a_q;

endmodule // rseq_top
`default_nettype wire

//--- rseq_top_props.sv
/* assertions on the rseq_top ports.
 assumes one clock domain; bound onto every rseq_top instance. */
`timescale 1ns/10ps
`default_nettype none
module rseq_top_props #(
	parameter [15:0] MS_CYCLES = 16'd4
) (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       target_switching_rail_enable,
	input wire logic       enable_delay_pending,
	input wire logic       enable_request,
	input wire logic [7:0] rail5_mask_a_out
);
	localparam int D2M = 2 * MS_CYCLES - 1;
	localparam int D4M = 4 * MS_CYCLES - 1;
	localparam int PMAX = 64 * MS_CYCLES;
	logic [7:0] ma_q, sb_q, dly_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// shadow copies of the writes to 8'h10, 8'h11 and 8'h12
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ma_q <= 8'h00;
			sb_q <= 8'h80;
			dly_q <= 8'h00;
		end else if (reg_wr_en) begin
			if (reg_addr == 8'h10) ma_q <= reg_wdata;
			if (reg_addr == 8'h11) sb_q <= reg_wdata;
			if (reg_addr == 8'h12) dly_q <= reg_wdata;
		end
	end
	chk_rvalid_pulse: assert property (1 |=> reg_rvalid == $past(reg_rd_en))
		else $error("read valid misplaced");
	chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved");
	chk_unmapped_zero: assert property (reg_rd_en && !(reg_addr inside {[8'h10:8'h13]})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_rail5_write: assert property (reg_wr_en && reg_addr == 8'h13
		|=> rail5_mask_a_out == $past(reg_wdata)) else $error("rail5 mask not written");
	chk_pending_match: assert property ($rose(enable_delay_pending)
		|-> ##[0:PMAX] !enable_delay_pending) else $error("pending too long");
	chk_enable_quiet: assert property (!enable_delay_pending
		|=> $stable(target_switching_rail_enable)) else $error("enable moved idle");
	chk_enable_toward: assert property ($changed(target_switching_rail_enable)
		|-> target_switching_rail_enable == $past(enable_request)) else $error("enable wrong way");
	chk_rise_zero: assert property ($rose(enable_request) && dly_q[2:0] == 3'h0
		|=> target_switching_rail_enable) else $error("undelayed rise late");
	chk_rise_two_ms: assert property ($rose(enable_request) && dly_q[2:0] == 3'h1
		|-> ##D2M !target_switching_rail_enable ##1 target_switching_rail_enable)
		else $error("2 ms rise wrong");
	chk_fall_four_ms: assert property ($fell(enable_request) && dly_q[5:3] == 3'h2
		|-> ##D4M target_switching_rail_enable ##1 !target_switching_rail_enable)
		else $error("4 ms fall wrong");
	chk_force_one: assert property ((sb_q == 8'h1f && ma_q == 8'hff) [*8]
		|-> enable_request) else $error("forced select not requesting");
	cover property ($rose(target_switching_rail_enable));
	cover property ($fell(target_switching_rail_enable));
	cover property (reg_rvalid && reg_rdata == 8'ha5);
endmodule // rseq_top_props
bind rseq_top rseq_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (.core_clk, .resetn, .reg_addr,
	.reg_wdata, .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rvalid, .target_switching_rail_enable,
	.enable_delay_pending, .enable_request, .rail5_mask_a_out);
`default_nettype wire

//--- rseq_host_model.sv
/* host side: drives control pins and power-good levels.
 assumes the bench sets the wanted levels. */
`timescale 1ns/10ps
`default_nettype none
module rseq_host_model (
	input  wire logic       core_clk,
	input  wire logic [5:0] ctl_want,
	input  wire logic [9:0] pg_want,
	output var  logic [5:0] ctl_pins,
	output var  logic [9:0] pg_pins
);
	// levels move away from the sampling edge
	always @(negedge core_clk) begin
		ctl_pins <= ctl_want;
		pg_pins <= pg_want;
	end
endmodule // rseq_host_model
`default_nettype wire

//--- rseq_top_tb.sv
/* self-checking bench for rseq_top.
 assumes MS_CYCLES shortened to 4 cycles per ms. */
`timescale 1ns/10ps
`default_nettype none
module rseq_top_tb;
	localparam int M = 4;
	logic       core_clk = 1'b0, resetn = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [5:0] ctl = 6'h00;
	logic [9:0] pg = 10'h000;
	wire  [7:0] reg_rdata, r5;
	wire        reg_rvalid, en, pend, req;
	wire  [5:0] ctl_pins;
	wire  [9:0] pg_pins;
	int         fail_count = 0, checked = 0;
	always #12.5 core_clk = ~core_clk;
	rseq_host_model host (.core_clk, .ctl_want(ctl), .pg_want(pg), .ctl_pins, .pg_pins);
	rseq_top #(.MS_CYCLES(16'd4)) dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr_en,
		.reg_rd_en, .reg_rdata, .reg_rvalid, .control_input_1(ctl_pins[0]),
		.control_input_2(ctl_pins[1]), .control_input_3(ctl_pins[2]),
		.control_input_4(ctl_pins[3]), .control_input_5(ctl_pins[4]),
		.control_input_6(ctl_pins[5]), .power_good_flag(pg_pins),
		.target_switching_rail_enable(en), .enable_delay_pending(pend),
		.enable_request(req), .rail5_mask_a_out(r5));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		chk("read valid", 1, reg_rvalid);
		chk("read data", exp, reg_rdata);
	endtask
	task automatic settle;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic t_regs;
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h80);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		wr(8'h13, 8'ha5);
		chk("rail5 mask out", 8'ha5, r5);
		rd(8'h13, 8'ha5);
		rd(8'h20, 8'h00);
		$display("regs done");
	endtask
	task automatic t_select;
		int p;
		wr(8'h10, 8'hff);
		for (int c = 0; c < 7; c++) begin
			p = (24'h15a708 >> (3 * c)) & 7; // pin index per code, 3 bits each
			wr(8'h11, {3'h0, 3'(c), 2'h3});
			ctl = 6'h3f & ~(6'h01 << p);
			settle;
			chk("request other pins", 0, req);
			ctl = 6'h01 << p;
			settle;
			chk("request chosen pin", 1, req);
		end
		ctl = 6'h00;
		wr(8'h11, 8'h1f);
		repeat (10) @(negedge core_clk);
		chk("forced request", 1, req);
		$display("select done");
	endtask
	task automatic t_mask;
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h1c);
		for (int i = 0; i < 10; i++) begin
			pg = 10'h3ff & ~(10'h001 << i);
			settle;
			chk("request good low", 0, req);
			if (i < 8) wr(8'h10, 8'h01 << i);
			else wr(8'h11, 8'h1c | (8'h01 << (i - 8)));
			settle;
			chk("request good masked", 1, req);
			wr(8'h10, 8'h00);
			wr(8'h11, 8'h1c);
		end
		pg = 10'h3ff;
		settle;
		chk("request all good", 1, req);
		$display("mask done");
	endtask
	function automatic int ms_of(input int c);
		return (64'h4020181008040200 >> (8 * c)) & 8'hff;
	endfunction
	task automatic meas(input logic lvl, input int e);
		int n;
		int k;
		n = 0;
		k = 0;
		ctl[0] = lvl;
		while (req !== lvl && k < 20) begin
			@(negedge core_clk);
			k++;
		end
		while (en !== lvl && n < 600) begin
			@(negedge core_clk);
			n++;
		end
		chk("edge delay", 1, e == 0 ? n == 1 : n * 10 >= e * 9 && n * 10 <= e * 11);
	endtask
	task automatic t_delay;
		wr(8'h10, 8'hff);
		wr(8'h11, 8'h03);
		for (int r = 0; r < 8; r++) begin
			wr(8'h12, {2'h0, 3'(7 - r), 3'(r)});
			meas(1'b1, M * ms_of(r));
			meas(1'b0, M * ms_of(7 - r));
		end
		$display("delay done");
	endtask
	task automatic t_glitch;
		wr(8'h12, 8'h03);
		ctl[0] = 1'b1;
		repeat (12) @(negedge core_clk);
		ctl[0] = 1'b0;
		settle;
		chk("enable after pulse", 0, en);
		chk("pending after pulse", 0, pend);
		$display("glitch done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		t_regs;
		t_select;
		t_mask;
		t_delay;
		t_glitch;
		final_report;
	end
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
endmodule // rseq_top_tb
`default_nettype wire
